// File: inc/prpm_pkg.sv
package prpm_pkg;
    // configuration space byte addresses, capability block relative to 00h
    localparam logic [7:0] CMD_OFFSET = 8'h04;
    localparam logic [7:0] PM_CAP_OFFSET = 8'hdc;
    localparam logic [7:0] PM_CSR_OFFSET = 8'he0;
    // fixed fields of the capability header
    localparam logic [7:0] PM_CAPABILITY_IDENTIFIER = 8'h01;
    localparam logic [7:0] PM_NEXT_CAPABILITY_POINTER = 8'he4;
    localparam logic [4:0] PME_SUPPORT_AUX = 5'h19;
    localparam logic [4:0] PME_SUPPORT_NO_AUX = 5'h09;
    localparam logic [2:0] PM_SPEC_VERSION = 3'h2;
    localparam logic PM_DSI = 1'b1;
    // command register field positions
    localparam int CMD_IO_BIT = 0;
    localparam int CMD_MEM_BIT = 1;
    // control/status field positions
    localparam int CSR_STATE_LSB = 0;
    localparam int CSR_PME_EN_BIT = 8;
    localparam int CSR_PME_STATUS_BIT = 15;
    // power state output codes
    localparam logic [1:0] PWR_OUT_RESET = 2'h0;
    localparam logic [1:0] PWR_OUT_LEGACY = 2'h1;
    localparam logic [1:0] PWR_OUT_ACTIVE = 2'h3;
    localparam logic [1:0] PM_STATE_RESET = 2'h0;
    // clocks allowed for clock synchronisation after reset release
    localparam int SETTLE_CLOCKS = 512;
    localparam int SETTLE_W = 10;
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CLOCKS - 1);

    typedef enum logic [3:0] {
        ST_RESET_PWR = 4'h1,
        ST_SETTLE = 4'h2,
        ST_D0_UNINIT = 4'h4,
        ST_D0_ACTIVE = 4'h8
    } prpm_state_t;
endpackage

// File: inc/prpm_settle_if.sv
`timescale 1ns/1ns
interface prpm_settle_if;
    logic run;
    logic done;
    modport ctrl (output run, input done);
    modport timer (input run, output done);
endinterface

// File: src/prpm_settle_timer.sv
`timescale 1ns/1ns
module prpm_settle_timer
    import prpm_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    prpm_settle_if.timer tmr
);
    typedef struct packed {
        logic [SETTLE_W-1:0] count;
        logic done;
    } prpm_timer_t;

    prpm_timer_t st;
    prpm_timer_t next_st;

    // count clocks while run holds, done stays up until run drops
    always_comb begin
        next_st = st;
        if (!tmr.run) begin
            next_st.count = '0;
            next_st.done = 1'b0;
        end else if (!st.done) begin
            if (st.count == SETTLE_LAST) begin
                next_st.done = 1'b1; // R16
            end else begin
                next_st.count = st.count + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tmr.done = st.done;
endmodule

// File: src/prpm_top.sv
// Operation
// R1: in 66 MHz or PCI-X mode the host asserts the bus reset before stopping the bus clock.
// R2: while the bus reset is asserted all bus pins except the wake pin float, reset power state.
// R3: with clock-run enabled a stopped clock in reset is tolerated; host must clock on request.
// R4: the release of bus reset starts a fresh EEPROM load and clears the wakeup enable.
// R5: up to 512 clocks after release pass before pins are driven and transactions answered.
// R6: after reset the power state outputs show 01 with legacy wake from EEPROM, else 00.
// R7: the host may wait any time after reset before enabling memory or I/O decoding.
// R8: a write setting memory or I/O enable moves uninitialised D0 to active D0.
// R9: that same write drives both power state outputs high.
// R10: the auxiliary power-good reset returns every power management field to default.
// R11: bus reset release defaults every power management field except PME enable and status.
// R12: with no auxiliary power, PME enable and status are also cleared at bus reset release.
// R13: the capability spans two dwords at DCh and E0h, header first, then control/status.
// R14: the capability identifier byte always reads 01h.
// R15: the next item pointer byte reads E4h.
// R16: a clock counter from reset release keeps pins floating and requests ignored until done.
`timescale 1ns/1ns
module prpm_top
    import prpm_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic pci_rst_n,
    input wire logic aux_power,
    input wire logic pme_event,
    input wire logic eeprom_load_done,
    input wire logic legacy_wake_mode,
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0] cfg_be,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    output logic pci_drive_en,
    output logic eeprom_load_start,
    output logic wake_enable,
    output logic [1:0] power_state_outputs,
    output logic pme_n_out,
    output logic pme_n_oe
);
    typedef struct packed {
        prpm_state_t fsm;
        logic [1:0] rst_sync;
        logic rst_prev;
        logic [1:0] aux_sync;
        logic cmd_io;
        logic cmd_mem;
        logic [1:0] pm_state;
        logic pme_en;
        logic pme_status;
        logic ack;
        logic [31:0] rdata;
        logic drive_en;
        logic load_start;
        logic wake_en;
        logic [1:0] pwr_out;
        logic pme_assert;
    } prpm_top_t;

    localparam prpm_top_t RESET_VALUE = '{
        fsm: ST_RESET_PWR,
        pwr_out: PWR_OUT_RESET,
        pm_state: PM_STATE_RESET,
        default: '0
    };

    prpm_top_t st;
    prpm_top_t next_st;
    prpm_settle_if settle ();

    prpm_settle_timer u_settle (
        .core_clk(core_clk),
        .reset(reset),
        .tmr(settle)
    );

    logic rst_active;
    logic rst_release;
    logic decode_on;
    logic [15:0] pmc_word;
    logic [15:0] csr_word;

    // reset pin level and its release edge, taken after the synchroniser
    assign rst_active = !st.rst_sync[1];
    assign rst_release = st.rst_sync[1] && !st.rst_prev;
    assign decode_on = (st.fsm == ST_D0_UNINIT) || (st.fsm == ST_D0_ACTIVE);
    assign settle.run = (st.fsm == ST_SETTLE);

    // capability and control/status words as read
    always_comb begin
        pmc_word = '0;
        pmc_word[15:11] = st.aux_sync[1] ? PME_SUPPORT_AUX : PME_SUPPORT_NO_AUX;
        pmc_word[5] = PM_DSI;
        pmc_word[2:0] = PM_SPEC_VERSION;
        csr_word = '0;
        csr_word[CSR_STATE_LSB +: 2] = st.pm_state;
        csr_word[CSR_PME_EN_BIT] = st.pme_en;
        csr_word[CSR_PME_STATUS_BIT] = st.pme_status;
    end

    // next state of the whole block
    always_comb begin
        next_st = st;
        next_st.rst_sync = {st.rst_sync[0], pci_rst_n};
        next_st.rst_prev = st.rst_sync[1];
        next_st.aux_sync = {st.aux_sync[0], aux_power};
        next_st.ack = 1'b0;
        next_st.load_start = 1'b0;

        // configuration access, only once decoding is up
        if (cfg_req && decode_on && !rst_active) begin
            next_st.ack = 1'b1;
            next_st.rdata = '0;
            if (cfg_write) begin
                if (cfg_addr == CMD_OFFSET && cfg_be[0]) begin
                    next_st.cmd_io = cfg_wdata[CMD_IO_BIT];
                    next_st.cmd_mem = cfg_wdata[CMD_MEM_BIT];
                    if ((cfg_wdata[CMD_IO_BIT] || cfg_wdata[CMD_MEM_BIT])
                        && st.fsm == ST_D0_UNINIT) begin
                        next_st.fsm = ST_D0_ACTIVE; // R8
                        next_st.pwr_out = PWR_OUT_ACTIVE; // R9
                    end
                end else if (cfg_addr == PM_CSR_OFFSET) begin
                    if (cfg_be[0]) begin
                        next_st.pm_state = cfg_wdata[CSR_STATE_LSB +: 2];
                    end
                    if (cfg_be[1]) begin
                        next_st.pme_en = cfg_wdata[CSR_PME_EN_BIT];
                        if (cfg_wdata[CSR_PME_STATUS_BIT]) begin
                            next_st.pme_status = 1'b0;
                        end
                    end
                end
            end else if (cfg_addr == CMD_OFFSET) begin
                next_st.rdata[CMD_IO_BIT] = st.cmd_io;
                next_st.rdata[CMD_MEM_BIT] = st.cmd_mem;
            end else if (cfg_addr == PM_CAP_OFFSET) begin
                // R13 R14 R15
                next_st.rdata = {pmc_word, PM_NEXT_CAPABILITY_POINTER, PM_CAPABILITY_IDENTIFIER};
            end else if (cfg_addr == PM_CSR_OFFSET) begin
                next_st.rdata = {16'h0000, csr_word}; // R13
            end
        end

        // wake event sets status, winning over a write-one clear in the same cycle
        if (pme_event && st.pme_en) begin
            next_st.pme_status = 1'b1;
        end

        // power sequencing
        case (st.fsm)
            ST_RESET_PWR: begin
                next_st.drive_en = 1'b0;
                if (rst_release) begin
                    next_st.fsm = ST_SETTLE;
                    next_st.load_start = 1'b1; // R4
                    next_st.wake_en = 1'b0; // R4
                    next_st.cmd_io = 1'b0;
                    next_st.cmd_mem = 1'b0;
                    next_st.pm_state = PM_STATE_RESET; // R11
                    next_st.pwr_out = PWR_OUT_RESET;
                    if (!st.aux_sync[1]) begin
                        next_st.pme_en = 1'b0; // R12
                        next_st.pme_status = 1'b0; // R12
                    end
                end
            end
            ST_SETTLE: begin
                if (settle.done) begin
                    next_st.fsm = ST_D0_UNINIT; // R5 R16
                    next_st.drive_en = 1'b1; // R5
                end
            end
            ST_D0_UNINIT: begin
                next_st.drive_en = 1'b1;
            end
            ST_D0_ACTIVE: begin
                next_st.drive_en = 1'b1;
            end
            default: begin
                next_st.fsm = ST_RESET_PWR;
            end
        endcase

        // eeprom result picks the post-reset power outputs
        if (eeprom_load_done && st.fsm != ST_RESET_PWR) begin
            next_st.wake_en = legacy_wake_mode;
            if (st.fsm != ST_D0_ACTIVE && next_st.fsm != ST_D0_ACTIVE) begin
                next_st.pwr_out = legacy_wake_mode ? PWR_OUT_LEGACY : PWR_OUT_RESET; // R6
            end
        end

        // bus reset held: float pins and fall back to reset power state
        if (rst_active) begin
            next_st.fsm = ST_RESET_PWR; // R2 R3
            next_st.drive_en = 1'b0; // R2
        end

        // wake pin is open drain and stays alive through reset
        next_st.pme_assert = next_st.pme_en && next_st.pme_status;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st <= RESET_VALUE; // R10
        end else begin
            st <= next_st;
        end
    end

    assign cfg_ack = st.ack;
    assign cfg_rdata = st.rdata;
    assign pci_drive_en = st.drive_en;
    assign eeprom_load_start = st.load_start;
    assign wake_enable = st.wake_en;
    assign power_state_outputs = st.pwr_out;
    assign pme_n_out = 1'b0;
    assign pme_n_oe = st.pme_assert;
endmodule

// File: verif/pci_reset_power_mgmt_cap_tb.sv
`timescale 1ns/1ns
module pci_reset_power_mgmt_cap_tb;
    import prpm_pkg::*;
    logic core_clk, reset, aux_power, pme_event, eeprom_load_done, legacy_wake_mode;
    logic pci_rst_n, cfg_req, cfg_write, cfg_ack, pci_drive_en, eeprom_load_start;
    logic wake_enable, pme_n_out, pme_n_oe;
    logic [7:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [3:0] cfg_be;
    logic [1:0] power_state_outputs;
    int mismatches, samples_checked;
    prpm_top uut (.core_clk(core_clk), .reset(reset), .pci_rst_n(pci_rst_n),
        .aux_power(aux_power), .pme_event(pme_event), .eeprom_load_done(eeprom_load_done),
        .legacy_wake_mode(legacy_wake_mode), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .pci_drive_en(pci_drive_en), .wake_enable(wake_enable),
        .eeprom_load_start(eeprom_load_start), .power_state_outputs(power_state_outputs),
        .pme_n_out(pme_n_out), .pme_n_oe(pme_n_oe));
    prpm_host_model host (.core_clk(core_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .pci_rst_n(pci_rst_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be));
    // clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_ready();
        for (int n = 0; n < 600 && pci_drive_en !== 1'b1; n++) @(negedge core_clk);
        check(32'(pci_drive_en), 32'h1, "drive after settle");
    endtask
    task automatic t_early();
        repeat (505) @(negedge core_clk);
        host.access(1'b0, PM_CAP_OFFSET, 32'h0, 4'hf);
        check(32'(host.got_ack), 32'h0, "ack while settling");
        check(32'(wake_enable), 32'h0, "wake after release");
        wait_ready();
    endtask
    task automatic t_header();
        host.access(1'b1, PM_CAP_OFFSET, 32'h0, 4'hf);
        host.access(1'b0, PM_CAP_OFFSET, 32'h0, 4'hf);
        check(host.last_rdata, {PME_SUPPORT_AUX, 5'h0, PM_DSI, 2'h0, PM_SPEC_VERSION,
            PM_NEXT_CAPABILITY_POINTER, PM_CAPABILITY_IDENTIFIER}, "header");
        check(32'(host.got_ack), 32'h1, "header answered");
        host.access(1'b0, 8'h08, 32'h0, 4'hf);
        check(host.last_rdata, 32'h0, "unmapped read");
    endtask
    task automatic t_wake();
        for (int i = 0; i < 2; i++) begin
            host.bus_reset(10);
            repeat (20) @(negedge core_clk);
            legacy_wake_mode = i[0];
            eeprom_load_done = 1'b1;
            @(negedge core_clk);
            eeprom_load_done = 1'b0;
            wait_ready();
            check(32'(power_state_outputs), i, "legacy code");
            check(32'(wake_enable), i, "wake from eeprom");
            host.access(1'b1, CMD_OFFSET, 32'h1 << i, 4'h1);
            check(32'(power_state_outputs), 32'h3, "active outputs");
            host.access(1'b0, CMD_OFFSET, 32'h0, 4'hf);
            check(host.last_rdata, 32'h1 << i, "command readback");
        end
    endtask
    task automatic pme_arm();
        host.access(1'b1, PM_CSR_OFFSET, 32'h103, 4'h3);
        pme_event = 1'b1;
        @(negedge core_clk);
        pme_event = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic t_pme();
        pme_arm();
        check(32'(pme_n_oe), 32'h1, "wake pin");
        check(32'(pme_n_out), 32'h0, "wake pin level");
        host.bus_reset(10);
        check(32'(pci_drive_en), 32'h0, "floating in reset");
        check(32'(pme_n_oe), 32'h1, "wake pin in reset");
        wait_ready();
        check(32'(wake_enable), 32'h0, "wake cleared at release");
        host.access(1'b0, PM_CSR_OFFSET, 32'h0, 4'hf);
        check(host.last_rdata, 32'h8100, "kept with aux");
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        wait_ready();
        host.access(1'b0, PM_CSR_OFFSET, 32'h0, 4'hf);
        check(host.last_rdata, 32'h0, "aux reset");
        pme_arm();
        aux_power = 1'b0;
        host.bus_reset(10);
        wait_ready();
        host.access(1'b0, PM_CSR_OFFSET, 32'h0, 4'hf);
        check(host.last_rdata, 32'h0, "cleared without aux");
    endtask
    // status clear by writing one, and a wake event winning over that clear
    task automatic t_pme_clear();
        pme_arm();
        host.access(1'b1, PM_CSR_OFFSET, 32'h8100, 4'h2);
        host.access(1'b0, PM_CSR_OFFSET, 32'h0, 4'hf);
        check(host.last_rdata, 32'h0103, "status cleared");
        check(32'(pme_n_oe), 32'h0, "wake pin released");
        pme_event = 1'b1;
        host.access(1'b1, PM_CSR_OFFSET, 32'h8100, 4'h2);
        pme_event = 1'b0;
        host.access(1'b0, PM_CSR_OFFSET, 32'h0, 4'hf);
        check(host.last_rdata, 32'h8103, "event beats clear");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #(40 * 6000);
        mismatches++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {reset, aux_power, pme_event, eeprom_load_done, legacy_wake_mode} = 5'b11000;
        mismatches = 0;
        samples_checked = 0;
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        t_early();
        t_header();
        t_wake();
        t_pme_clear();
        t_pme();
        tally_and_finish();
    end
endmodule
bind prpm_top prpm_monitor mon (.core_clk(core_clk), .reset(reset), .pci_rst_n(pci_rst_n),
    .eeprom_load_done(eeprom_load_done), .legacy_wake_mode(legacy_wake_mode),
    .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_be(cfg_be), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .pci_drive_en(pci_drive_en),
    .eeprom_load_start(eeprom_load_start), .wake_enable(wake_enable),
    .power_state_outputs(power_state_outputs));

// File: verif/prpm_host_model.sv
`timescale 1ns/1ns
module prpm_host_model (
    input wire logic core_clk,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    output logic pci_rst_n,
    output logic cfg_req,
    output logic cfg_write,
    output logic [7:0] cfg_addr,
    output logic [31:0] cfg_wdata,
    output logic [3:0] cfg_be
);
    logic got_ack;
    logic [31:0] last_rdata;
    // idle bus at time zero
    initial begin
        pci_rst_n = 1'b1;
        cfg_req = 1'b0;
        cfg_write = 1'b0;
        cfg_addr = 8'h0;
        cfg_wdata = 32'h0;
        cfg_be = 4'h0;
    end
    // bus reset with the clock left running, any wait after it
    task automatic bus_reset(input int hold);
        @(negedge core_clk);
        pci_rst_n <= 1'b0;
        repeat (hold) @(negedge core_clk);
        pci_rst_n <= 1'b1;
    endtask
    // one config cycle held until answered or a bound runs out
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] be);
        @(negedge core_clk);
        {cfg_req, cfg_write, cfg_addr, cfg_wdata, cfg_be} <= {1'b1, wr, a, d, be};
        got_ack = 1'b0;
        for (int i = 0; i < 4 && !got_ack; i++) begin
            @(posedge core_clk);
            #1;
            got_ack = cfg_ack;
            last_rdata = cfg_rdata;
        end
        @(negedge core_clk);
        {cfg_req, cfg_addr, cfg_wdata} <= {1'b0, ~a, ~d}; // released bus shows no stale address or data value
    endtask
endmodule

// File: verif/prpm_monitor.sv
`timescale 1ns/1ns
module prpm_monitor (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic pci_rst_n,
    input wire logic eeprom_load_done,
    input wire logic legacy_wake_mode,
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0] cfg_be,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic pci_drive_en,
    input wire logic eeprom_load_start,
    input wire logic wake_enable,
    input wire logic [1:0] power_state_outputs
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [2:0] rst_hist;
    logic [10:0] settle_cnt;
    logic quiet;
    logic taken;
    assign quiet = (&rst_hist) && pci_rst_n;
    assign taken = cfg_req && pci_drive_en && quiet;
    // reset pin history and clocks since the load pulse
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rst_hist <= 3'h0;
            settle_cnt <= 11'h0;
        end else begin
            rst_hist <= {rst_hist[1:0], pci_rst_n};
            if (eeprom_load_start) begin
                settle_cnt <= 11'h1;
            end else if (!pci_drive_en && settle_cnt != 11'h0) begin
                settle_cnt <= settle_cnt + 11'h1;
            end
        end
    end
    chk_refused_early: assert property (cfg_req && !pci_drive_en |=> !cfg_ack)
        else $error("ack while settling");
    chk_ack_cause: assert property (cfg_ack |-> $past(cfg_req && pci_drive_en))
        else $error("ack without request");
    chk_read_header: assert property (taken && !cfg_write && cfg_addr == 8'hdc
        |=> cfg_ack && cfg_rdata[15:0] == 16'he401) else $error("bad header");
    chk_rst_floats: assert property ($fell(pci_rst_n) |-> ##[1:3] !pci_drive_en)
        else $error("pins driven in reset");
    chk_load_on_release: assert property ($rose(pci_rst_n) |-> ##[2:5] eeprom_load_start)
        else $error("no load after release");
    chk_load_clears_wake: assert property ($rose(eeprom_load_start) |-> !wake_enable)
        else $error("wake kept at release");
    chk_settle_span: assert property ($rose(pci_drive_en) |-> settle_cnt inside {[11'd512:11'd514]})
        else $error("settle span wrong");
    chk_active_outputs: assert property (taken && cfg_write && cfg_addr == 8'h04 && cfg_be[0]
        && cfg_wdata[1:0] != 2'h0 |=> power_state_outputs == 2'h3) else $error("not active");
    chk_legacy_code: assert property (eeprom_load_done && quiet && !pci_drive_en
        && settle_cnt > 11'h4 |=> power_state_outputs == {1'b0, $past(legacy_wake_mode)})
        else $error("bad legacy code");
endmodule
